// [verilog/iopfs_pkg.sv]
// Constants, register map and helpers for the I/O function select block
`default_nettype none
package iopfs_pkg;

    // Pin and field geometry
    localparam int NPINS           = 13;
    localparam int FIRST_PIN       = 12;
    localparam int FIELD_W         = 6;
    localparam int GRP_W           = 3;
    localparam int LANE_W          = 8;
    localparam int FIELDS_PER_WORD = 4;
    localparam int NWORDS          = 4;
    localparam int IDX_W           = 2;

    // Field positions inside a selector word
    localparam int FIELD0_LSB = 0;
    localparam int FIELD1_LSB = 8;
    localparam int FIELD2_LSB = 16;
    localparam int FIELD3_LSB = 24;

    // Register byte addresses
    localparam logic [31:0] ADDR_PINS_12_15 = 32'h4000b1ac;
    localparam logic [31:0] ADDR_PINS_16_19 = 32'h4000b1b0;
    localparam logic [31:0] ADDR_PINS_20_23 = 32'h4000b1b4;
    localparam logic [31:0] ADDR_PIN_24     = 32'h4000b1b8;

    // Reset values
    localparam logic [31:0]        RST_WORD  = 32'h3f3f3f3f;
    localparam logic [7:0]         RST_PIN24 = 8'h3f;
    localparam logic [FIELD_W-1:0] FIELD_RST = 6'h3f;

    // Reserved bit mask of a selector word
    localparam logic [31:0] RSVD_MASK = 32'hc0c0c0c0;

    // Group selector value that lets the field reach the pin
    localparam logic [GRP_W-1:0] GRP_FUNCTION_ONE = 3'h1;

    // Returns {hit, word index} for a byte address
    function automatic logic [IDX_W:0] decode_addr(input logic [31:0] a);
        logic [IDX_W:0] r;
        r = '0;
        case (a)
            ADDR_PINS_12_15: r = {1'b1, 2'h0};
            ADDR_PINS_16_19: r = {1'b1, 2'h1};
            ADDR_PINS_20_23: r = {1'b1, 2'h2};
            ADDR_PIN_24:     r = {1'b1, 2'h3};
            default:         r = '0;
        endcase
        return r;
    endfunction : decode_addr

    // Packs four fields, highest pin on top, reserved bits zero
    function automatic logic [31:0] pack_word(
        input logic [FIELD_W-1:0] f3,
        input logic [FIELD_W-1:0] f2,
        input logic [FIELD_W-1:0] f1,
        input logic [FIELD_W-1:0] f0
    );
        return {2'h0, f3, 2'h0, f2, 2'h0, f1, 2'h0, f0};
    endfunction : pack_word

endpackage : iopfs_pkg
`default_nettype wire

// [verilog/iopfs_route.sv]
// Per-pin gate that passes a selector field only in function group one
`timescale 1ns/1ps
`default_nettype none
module iopfs_route
    import iopfs_pkg::*;
#(
    parameter int NUM_PINS = NPINS,
    parameter int FW       = FIELD_W,
    parameter int GW       = GRP_W
) (
    // Clock and synchronised reset
    input  wire logic                   clk_sys,
    input  wire logic                   rstn_s,
    // Stored selector fields and group selectors
    input  wire logic [NUM_PINS*FW-1:0] field_flat,
    input  wire logic [NUM_PINS*GW-1:0] group_flat,
    // Routed result
    output logic      [NUM_PINS*FW-1:0] func_r,
    output logic      [NUM_PINS-1:0]    en_r
);

    logic [NUM_PINS*FW-1:0] func_nxt;
    logic [NUM_PINS-1:0]    en_nxt;

    always_comb begin
        func_nxt = '0;
        en_nxt   = '0;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (group_flat[p*GW +: GW] == GW'(GRP_FUNCTION_ONE)) begin
                func_nxt[p*FW +: FW] = field_flat[p*FW +: FW];
                en_nxt[p]            = 1'b1;
            end
        end
    end

    // Unselected pins show zero so a stale field never leaks out
    always_ff @(posedge clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            func_r <= '0;
            en_r   <= '0;
        end else begin
            func_r <= func_nxt;
            en_r   <= en_nxt;
        end
    end

endmodule : iopfs_route
`default_nettype wire

// [verilog/iopfs_top.sv]
// APB register bank selecting the peripheral function of pins 12 to 24
//
// Functional notes
// - Four 6-bit fields per word, high pin top
// - Field drives pin only in group one
// - Four-pin words reset to 0x3F3F3F3F
// - Last register holds only pin 24 field
// - Pin 24 register resets to 3F
// - Words sit at consecutive addresses from 0x4000B1AC
`timescale 1ns/1ps
`default_nettype none
module iopfs_top
    import iopfs_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     resetn,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Group selectors, three bits per pin, pin 12 lowest
    input  wire logic [NPINS*GRP_W-1:0]   pin_group_selector,
    // Routed function per pin and its enable
    output logic      [NPINS*FIELD_W-1:0] peripheral_function_field,
    output logic      [NPINS-1:0]         pin_route_en
);

    // Reset release synchroniser
    logic [1:0] rst_sync_r;
    logic [1:0] rst_sync_nxt;
    logic       rstn_s;

    always_comb begin
        rst_sync_nxt = {rst_sync_r[0], 1'b1};
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= rst_sync_nxt;
        end
    end

    assign rstn_s = rst_sync_r[1];

    // Bus decode
    logic             setup;
    logic             access_done;
    logic [IDX_W:0]   dec;
    logic             hit;
    logic [IDX_W-1:0] idx;

    assign setup       = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign dec         = decode_addr(paddr);
    assign hit         = dec[IDX_W];
    assign idx         = dec[IDX_W-1:0];

    // Selector fields, one per pin
    logic [FIELD_W-1:0]       field_r   [NPINS];
    logic [FIELD_W-1:0]       field_nxt [NPINS];
    logic [FIELD_W-1:0]       fld_ext   [NWORDS*FIELDS_PER_WORD];
    logic [31:0]              word_view [NWORDS];
    logic [NPINS*FIELD_W-1:0] field_flat;

    always_comb begin
        for (int i = 0; i < NWORDS * FIELDS_PER_WORD; i++) begin
            fld_ext[i] = '0;
        end
        for (int i = 0; i < NPINS; i++) begin
            fld_ext[i] = field_r[i];
        end
        for (int w = 0; w < NWORDS; w++) begin
            word_view[w] = pack_word(fld_ext[w*FIELDS_PER_WORD + 3],
                                     fld_ext[w*FIELDS_PER_WORD + 2],
                                     fld_ext[w*FIELDS_PER_WORD + 1],
                                     fld_ext[w*FIELDS_PER_WORD]);
        end
    end

    always_comb begin
        field_flat = '0;
        for (int i = 0; i < NPINS; i++) begin
            field_flat[i*FIELD_W +: FIELD_W] = field_r[i];
        end
    end

    // Write takes effect only at the completing access edge
    always_comb begin
        int pin;
        pin = 0;
        for (int i = 0; i < NPINS; i++) begin
            field_nxt[i] = field_r[i];
        end
        if (access_done && pwrite && hit) begin
            for (int k = 0; k < FIELDS_PER_WORD; k++) begin
                pin = int'(idx) * FIELDS_PER_WORD + k;
                if (pin < NPINS) begin
                    // bits 7:6 of each lane dropped
                    field_nxt[pin] = pwdata[k*LANE_W +: FIELD_W];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            for (int i = 0; i < NPINS; i++) begin
                field_r[i] <= FIELD_RST;
            end
        end else begin
            for (int i = 0; i < NPINS; i++) begin
                field_r[i] <= field_nxt[i];
            end
        end
    end

    // APB answer: registered in setup, so every access has no wait state
    logic [31:0] prdata_nxt;
    logic        pready_nxt;
    logic        pslverr_nxt;

    always_comb begin
        pready_nxt  = setup;
        pslverr_nxt = setup & ~hit;
        prdata_nxt  = '0;
        if (setup && hit && !pwrite) begin
            prdata_nxt = word_view[idx];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn_s) begin
        if (!rstn_s) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_nxt;
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    // Pin routing
    iopfs_route #(
        .NUM_PINS (NPINS),
        .FW       (FIELD_W),
        .GW       (GRP_W)
    ) iopfs_route_i (
        .clk_sys    (clk_sys),
        .rstn_s     (rstn_s),
        .field_flat (field_flat),
        .group_flat (pin_group_selector),
        .func_r     (peripheral_function_field),
        .en_r       (pin_route_en)
    );

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn_s);

    sequence seq_read_setup(logic [31:0] a);
        setup && !pwrite && paddr == a;
    endsequence

    sequence seq_answer;
        pready ##1 !pready;
    endsequence

    sequence seq_write_done(logic [31:0] a);
        access_done && pwrite && paddr == a;
    endsequence

    a_apb_answer_once: assert property (
        setup |=> seq_answer
    ) else $error("APB answer not a single cycle after setup");

    a_word_packing: assert property (
        seq_read_setup(ADDR_PINS_12_15) |=>
            prdata[29:24] == $past(field_r[3]) &&
            prdata[21:16] == $past(field_r[2]) &&
            prdata[13:8]  == $past(field_r[1]) &&
            prdata[5:0]   == $past(field_r[0])
    ) else $error("Field order in selector word wrong");

    a_write_lane_map: assert property (
        seq_write_done(ADDR_PINS_16_19) |=>
            field_r[7] == $past(pwdata[29:24]) &&
            field_r[4] == $past(pwdata[5:0])
    ) else $error("Write lane did not reach its pin field");

    a_route_gate_on: assert property (
        rstn_s && pin_group_selector[GRP_W-1:0] == GRP_FUNCTION_ONE |=>
            pin_route_en[0] &&
            peripheral_function_field[FIELD_W-1:0] == $past(field_r[0])
    ) else $error("Group one pin not routed");

    a_route_gate_off: assert property (
        pin_group_selector[NPINS*GRP_W-1 -: GRP_W] != GRP_FUNCTION_ONE |=>
            !pin_route_en[NPINS-1] &&
            peripheral_function_field[NPINS*FIELD_W-1 -: FIELD_W] == '0
    ) else $error("Pin outside group one still routed");

    a_reset_words: assert property (
        !$past(rstn_s) |->
            word_view[0] == RST_WORD && word_view[1] == RST_WORD &&
            word_view[2] == RST_WORD
    ) else $error("Four-pin word reset value wrong");

    a_pin24_only: assert property (
        seq_write_done(ADDR_PIN_24) |=>
            word_view[3][31:FIELD_W] == '0 &&
            field_r[NPINS-1] == $past(pwdata[5:0]) &&
            field_r[NPINS-2] == $past(field_r[NPINS-2])
    ) else $error("Pin 24 register holds more than its field");

    a_pin24_reset: assert property (
        !$past(rstn_s) |-> word_view[3] == {24'h000000, RST_PIN24}
    ) else $error("Pin 24 register reset value wrong");

    a_addr_map_read: assert property (
        seq_read_setup(ADDR_PINS_20_23) |=>
            !pslverr && prdata == $past(word_view[2])
    ) else $error("Word address map read mismatch");

    a_unmapped_error: assert property (
        setup && !hit |=> pslverr && prdata == '0 && pready
    ) else $error("Unmapped address not refused");

    a_reserved_zero: assert property (
        pready |-> (prdata & RSVD_MASK) == '0
    ) else $error("Reserved bits read nonzero");

    a_write_lane_low: assert property (
        seq_write_done(ADDR_PINS_12_15) |=>
            field_r[3] == $past(pwdata[29:24]) &&
            field_r[2] == $past(pwdata[21:16]) &&
            field_r[1] == $past(pwdata[13:8]) &&
            field_r[0] == $past(pwdata[5:0])
    ) else $error("Lane order wrong in lowest selector word");

    a_write_top_word: assert property (
        seq_write_done(ADDR_PINS_20_23) |=>
            field_r[11] == $past(pwdata[29:24]) &&
            field_r[8] == $past(pwdata[5:0]) &&
            field_r[7] == $past(field_r[7])
    ) else $error("Third word write missed its pins");

    a_read_mid_word: assert property (
        seq_read_setup(ADDR_PINS_16_19) |=>
            !pslverr &&
            prdata[29:24] == $past(field_r[7]) &&
            prdata[5:0] == $past(field_r[4])
    ) else $error("Second word read shows wrong pins");

    a_read_pin24: assert property (
        seq_read_setup(ADDR_PIN_24) |=>
            prdata == {26'h0, $past(field_r[NPINS-1])}
    ) else $error("Pin 24 read shows more than its field");

    // Refused and read accesses must leave every field alone
    a_bad_write_kept: assert property (
        access_done && pwrite && !hit |=> field_flat == $past(field_flat)
    ) else $error("Unmapped write changed a field");

    a_read_keeps_fields: assert property (
        access_done && !pwrite |=> field_flat == $past(field_flat)
    ) else $error("Read access changed a field");

    a_fields_idle: assert property (
        !access_done |=> field_flat == $past(field_flat)
    ) else $error("Field changed without an access");

    a_idle_quiet: assert property (
        !setup |=> !pready && !pslverr && prdata == '0
    ) else $error("APB answer outside the first access cycle");

    // Route outputs still show reset one edge after release
    a_reset_outputs: assert property (
        !$past(rstn_s) |-> !pready && pin_route_en == '0 &&
            peripheral_function_field == '0
    ) else $error("Outputs not quiet after reset release");

    a_route_gate_mid: assert property (
        rstn_s && pin_group_selector[7*GRP_W +: GRP_W] == GRP_FUNCTION_ONE
            |=> pin_route_en[7] &&
            peripheral_function_field[7*FIELD_W +: FIELD_W] ==
                $past(field_r[7])
    ) else $error("Group one pin 19 not routed");

endmodule : iopfs_top
`default_nettype wire

// [tb/iopfs_top_test.sv]
// Self-checking testbench for the I/O function select register bank
`timescale 1ns/1ps
`default_nettype none
module iopfs_top_test
    import iopfs_pkg::*;
;
    logic                     clk_sys;
    logic                     resetn;
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [31:0]              paddr;
    logic [31:0]              pwdata;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic [NPINS*GRP_W-1:0]   grp;
    logic [NPINS*FIELD_W-1:0] func;
    logic [NPINS-1:0]         route_en;
    logic [31:0]              m [4];
    logic [31:0]              rd;
    logic                     err;
    int                       n_fail;
    int                       n_tests;

    localparam logic [31:0] ADR [4] = '{ADDR_PINS_12_15, ADDR_PINS_16_19,
                                        ADDR_PINS_20_23, ADDR_PIN_24};
    // Reserved bits set in some words so masking is exercised
    localparam logic [31:0] WD [4]  = '{32'hd5eaccf1, 32'h0a1b2c3d,
                                        32'hffffffff, 32'hfffffff5};
    // Neighbour words, one past the end, misaligned, and an alias attempt
    localparam logic [31:0] BAD [4] = '{32'h4000b1a8, 32'h4000b1bc,
                                        32'h4000b1ad, 32'h0000b1ac};

    iopfs_top iopfs_top_i (
        .clk_sys                   (clk_sys),
        .resetn                    (resetn),
        .psel                      (psel),
        .penable                   (penable),
        .pwrite                    (pwrite),
        .paddr                     (paddr),
        .pwdata                    (pwdata),
        .prdata                    (prdata),
        .pready                    (pready),
        .pslverr                   (pslverr),
        .pin_group_selector        (grp),
        .peripheral_function_field (func),
        .pin_route_en              (route_en)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_f(input logic got, input logic exp);
        chk_w({31'h0, got}, {31'h0, exp});
    endtask : chk_f

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk_f(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic check_regs();
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ADR[i], 32'h0);
            chk_w(rd, m[i]);
            chk_f(err, 1'b0);
        end
    endtask : check_regs

    // Expected routing is rebuilt from the bench's own register model
    task automatic chk_route();
        logic [NPINS*FIELD_W-1:0] ef;
        logic [NPINS-1:0]         ee;
        repeat (3) @(posedge clk_sys);
        for (int p = 0; p < NPINS; p++) begin
            ee[p] = (grp[p*GRP_W +: GRP_W] === GRP_FUNCTION_ONE);
            ef[p*FIELD_W +: FIELD_W] = ee[p] ? m[p/4][(p%4)*8 +: 6] : 6'h00;
        end
        chk_w(func[31:0], ef[31:0]);
        chk_w(func[63:32], ef[63:32]);
        chk_w({18'h0, func[77:64]}, {18'h0, ef[77:64]});
        chk_w({19'h0, route_en}, {19'h0, ee});
    endtask : chk_route

    task automatic rst_seq();
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 3; i++)
            m[i] = 32'h3f3f3f3f;
        m[3] = 32'h0000003f;
    endtask : rst_seq

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        grp = '0;
        n_fail = 0;
        n_tests = 0;
        rst_seq();
        check_regs();
        grp <= {NPINS{GRP_FUNCTION_ONE}};
        chk_route();
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADR[i], WD[i]);
            chk_f(err, 1'b0);
            m[i] = WD[i] & ((i == 3) ? 32'h0000003f : ~RSVD_MASK);
        end
        check_regs();
        chk_route();
        // Every group code lands on every pin across the sweep
        for (int c = 0; c < 8; c++) begin
            for (int p = 0; p < NPINS; p++)
                grp[p*GRP_W +: GRP_W] <= GRP_W'((p + c) % 8);
            chk_route();
        end
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, BAD[i], 32'h0);
            chk_f(err, 1'b1);
            apb(1'b0, BAD[i], 32'h0);
            chk_w(rd, 32'h0);
            chk_f(err, 1'b1);
        end
        check_regs();
        rst_seq();
        check_regs();
        chk_route();
        end_of_test();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        $display("Watchdog expired at t=%0t", $time);
        end_of_test();
    end
endmodule : iopfs_top_test
`default_nettype wire
